// file: hdl/plpc_top.sv
// link coding, carrier, loop-back, negotiation and pause control
`timescale 1ns/10ps
`default_nettype none
module plpc_top import plpc_pkg::*; #(
	parameter int FLP_BIT_CYC = FLP_BIT_US * CLK_MHZ
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// host control register 0
	input wire logic host_ctrl0_wr,
	input wire logic [15:0] host_ctrl0_wdata,
	output logic [15:0] host_ctrl0_q,
	// transceiver control 0 and advertisement 4 contents
	input wire logic [15:0] phy_ctrl0,
	input wire logic [15:0] phy_adv4,
	// line side
	input wire logic line_rx_nrzi,
	input wire logic line_rx_bit_tgl,
	output logic line_tx_nrzi_q,
	output logic line_tx_man_q,
	output logic flp_pulse_q,
	// partner ability word from the link pulse receiver
	input wire logic lp_word_stb,
	input wire logic [15:0] lp_word,
	// transmit serial stream from the encoder
	input wire logic tx_nrz_bit,
	input wire logic tx_bit_stb,
	input wire logic tx_active,
	// received nibbles and 10 Mb/s loop bits
	output logic [3:0] rx_nib_q,
	output logic rx_nib_vld_q,
	input wire logic rx_nib_ready,
	output logic rx_overrun_q,
	output logic rx10_bit_q,
	output logic rx10_stb_q,
	// link status
	output logic crs_q,
	output logic col_q,
	output logic speed100_q,
	output logic full_duplex_q,
	output logic an_done_q,
	output logic pause_en_q,
	// received control frames and pause state
	input wire logic ctrl_frame_stb,
	input wire logic [15:0] ctrl_opcode,
	input wire logic [15:0] ctrl_param,
	output logic tx_pause_q,
	output logic [15:0] pause_timer_q
);
	logic rst;
	logic loop_en, an_en;
	logic [15:0] host_d;

	// host control: a written reset bit lives one cycle, then clears
	always_comb begin
		host_d = host_ctrl0_q;
		host_d[HOST0_RESET_BIT] = 1'b0;
		if (host_ctrl0_wr) begin
			host_d = host_ctrl0_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			host_ctrl0_q <= 16'h0000;
		end else begin
			host_ctrl0_q <= host_d;
		end
	end

	assign rst = !reset_n || host_ctrl0_q[HOST0_RESET_BIT];
	assign loop_en = phy_ctrl0[PHY0_LOOP_BIT];
	assign an_en = phy_ctrl0[PHY0_AN_EN_BIT];

	// pin synchronisers; the third toggle stage only feeds the edge detect
	logic rxd_s1_q, rxd_s2_q, tgl_s1_q, tgl_s2_q, tgl_s3_q;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rxd_s1_q <= 1'b0;
			rxd_s2_q <= 1'b0;
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
		end else begin
			rxd_s1_q <= line_rx_nrzi;
			rxd_s2_q <= rxd_s1_q;
			tgl_s1_q <= line_rx_bit_tgl;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
		end
	end

	// transmit side: NRZ to NRZI, Manchester, idle on the NRZI line in loop-back
	logic tx_nrzi_q, tx_nrzi_d, idle_nrzi_q, idle_nrzi_d, lb_evt_q;
	logic man_half_q, man_half_d, line_nrzi_d, line_man_d;
	logic rx10_bit_d, rx10_stb_d;
	always_comb begin
		tx_nrzi_d = tx_nrzi_q;
		idle_nrzi_d = idle_nrzi_q;
		line_man_d = line_tx_man_q;
		man_half_d = 1'b0;
		if (tx_bit_stb) begin
			tx_nrzi_d = tx_nrzi_q ^ tx_nrz_bit;
			// idle is all ones, so its NRZI form toggles on every bit
			idle_nrzi_d = !idle_nrzi_q;
			line_man_d = !tx_nrz_bit;
			man_half_d = 1'b1;
		end else if (man_half_q) begin
			line_man_d = !line_tx_man_q;
		end
		line_nrzi_d = loop_en ? idle_nrzi_d : tx_nrzi_d;
		// second half-bit of the Manchester cell carries the data
		rx10_stb_d = loop_en && !speed100_q && man_half_q;
		rx10_bit_d = !line_tx_man_q;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tx_nrzi_q <= 1'b0;
			idle_nrzi_q <= 1'b0;
			line_tx_nrzi_q <= 1'b0;
			line_tx_man_q <= 1'b0;
			man_half_q <= 1'b0;
			lb_evt_q <= 1'b0;
			rx10_bit_q <= 1'b0;
			rx10_stb_q <= 1'b0;
		end else begin
			tx_nrzi_q <= tx_nrzi_d;
			idle_nrzi_q <= idle_nrzi_d;
			line_tx_nrzi_q <= line_nrzi_d;
			line_tx_man_q <= line_man_d;
			man_half_q <= man_half_d;
			lb_evt_q <= tx_bit_stb;
			rx10_bit_q <= rx10_bit_d;
			rx10_stb_q <= rx10_stb_d;
		end
	end

	// receive chain, one step per recovered bit
	logic [10:0] lfsr_q, lfsr_d;
	logic [CS_WIN-1:0] win_q, win_d;
	logic [4:0] grp_q, grp_d, dec;
	logic [2:0] gcnt_q, gcnt_d;
	logic crs_rx_q, crs_rx_d, prev_q, prev_d, push_q, push_d;
	logic [3:0] nib_q, nib_d;
	logic bit_evt, nrzi_in, nrz, key, dbit, ovr_d;
	plpc_stream_if #(.W(NIB_W)) fin ();
	plpc_stream_if #(.W(NIB_W)) fout ();

	always_comb begin
		bit_evt = tgl_s2_q ^ tgl_s3_q;
		nrzi_in = rxd_s2_q;
		if (loop_en) begin
			bit_evt = lb_evt_q && speed100_q;
			nrzi_in = tx_nrzi_q;
		end
		nrz = nrzi_in ^ prev_q;
		key = lfsr_q[10] ^ lfsr_q[8];
		dbit = nrz ^ key;
		lfsr_d = lfsr_q;
		win_d = win_q;
		grp_d = grp_q;
		gcnt_d = gcnt_q;
		crs_rx_d = crs_rx_q;
		prev_d = prev_q;
		nib_d = nib_q;
		push_d = 1'b0;
		dec = 5'h00;
		if (bit_evt) begin
			prev_d = nrzi_in;
			lfsr_d = {lfsr_q[9:0], key};
			win_d = {win_q[CS_WIN-2:0], dbit};
			grp_d = {grp_q[3:0], dbit};
			if (!crs_rx_q) begin
				if (plpc_two_zeros(win_d)) begin
					crs_rx_d = 1'b1;
					gcnt_d = 3'h0;
				end
			end else if (gcnt_q == GROUP_LAST) begin
				gcnt_d = 3'h0;
				dec = plpc_decode(grp_d);
				case (grp_d)
					CG_T, CG_IDLE: crs_rx_d = 1'b0;
					CG_J, CG_K, CG_R: crs_rx_d = 1'b1;
					default: begin
						push_d = dec[4];
						nib_d = dec[3:0];
					end
				endcase
			end else begin
				gcnt_d = gcnt_q + 3'h1;
			end
		end
		// a nibble that finds the fifo full is lost and flagged
		ovr_d = rx_overrun_q || (push_q && !fin.ready);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lfsr_q <= DESCR_SEED;
			win_q <= '1;
			grp_q <= 5'h00;
			gcnt_q <= 3'h0;
			crs_rx_q <= 1'b0;
			prev_q <= 1'b0;
			nib_q <= 4'h0;
			push_q <= 1'b0;
			rx_overrun_q <= 1'b0;
		end else begin
			lfsr_q <= lfsr_d;
			win_q <= win_d;
			grp_q <= grp_d;
			gcnt_q <= gcnt_d;
			crs_rx_q <= crs_rx_d;
			prev_q <= prev_d;
			nib_q <= nib_d;
			push_q <= push_d;
			rx_overrun_q <= ovr_d;
		end
	end

	assign fin.data = nib_q;
	assign fin.valid = push_q;

	plpc_fifo #(.W(NIB_W), .DEPTH(RX_FIFO_DEPTH)) u_rx_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr(fin.snk),
		.rd(fout.src)
	);

	// output register so the nibble port comes from flops
	logic [3:0] onib_d;
	logic ovld_d;
	assign fout.ready = !rx_nib_vld_q || rx_nib_ready;
	always_comb begin
		onib_d = rx_nib_q;
		ovld_d = rx_nib_vld_q && !rx_nib_ready;
		if (fout.ready && fout.valid) begin
			onib_d = fout.data;
			ovld_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rx_nib_q <= 4'h0;
			rx_nib_vld_q <= 1'b0;
		end else begin
			rx_nib_q <= onib_d;
			rx_nib_vld_q <= ovld_d;
		end
	end

	// negotiation: bursts carry clock pulses and a data pulse per one bit
	plpc_an_t an_q, an_d;
	logic [15:0] acnt_q, acnt_d, lp_q, lp_d, com;
	logic [3:0] abit_q, abit_d;
	logic lps_q, lps_d, asp_q, asp_d, afd_q, afd_d, apa_q, apa_d, flp_d;
	always_comb begin
		an_d = an_q;
		acnt_d = acnt_q;
		abit_d = abit_q;
		lp_d = lp_q;
		lps_d = lps_q || lp_word_stb;
		asp_d = asp_q;
		afd_d = afd_q;
		apa_d = apa_q;
		flp_d = 1'b0;
		com = phy_adv4 & lp_q;
		if (lp_word_stb) begin
			lp_d = lp_word;
		end
		case (an_q)
			AN_IDLE: begin
				acnt_d = 16'h0000;
				abit_d = 4'h0;
				if (an_en) begin
					an_d = AN_SEND;
				end
			end
			AN_SEND: begin
				acnt_d = acnt_q + 16'h0001;
				if (acnt_q == 16'h0000) begin
					flp_d = 1'b1;
				end else if (acnt_q == 16'(FLP_BIT_CYC / 2)) begin
					flp_d = phy_adv4[abit_q];
				end
				if (acnt_q == 16'(FLP_BIT_CYC - 1)) begin
					acnt_d = 16'h0000;
					abit_d = abit_q + 4'h1;
					if (abit_q == 4'(ADV_BITS - 1)) begin
						an_d = AN_WAIT;
					end
				end
			end
			AN_WAIT: begin
				an_d = lps_q ? AN_DONE : AN_SEND;
				asp_d = com[ADV_100FD_BIT] || com[ADV_100HD_BIT];
				afd_d = com[ADV_100FD_BIT] ||
					(!com[ADV_100HD_BIT] && com[ADV_10FD_BIT]);
				apa_d = com[ADV_PAUSE_BIT];
			end
			AN_DONE: an_d = AN_DONE;
			default: an_d = AN_IDLE;
		endcase
		if (!an_en) begin
			an_d = AN_IDLE;
			lps_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			an_q <= AN_IDLE;
			acnt_q <= 16'h0000;
			abit_q <= 4'h0;
			lp_q <= 16'h0000;
			lps_q <= 1'b0;
			asp_q <= 1'b0;
			afd_q <= 1'b0;
			apa_q <= 1'b0;
			flp_pulse_q <= 1'b0;
		end else begin
			an_q <= an_d;
			acnt_q <= acnt_d;
			abit_q <= abit_d;
			lp_q <= lp_d;
			lps_q <= lps_d;
			asp_q <= asp_d;
			afd_q <= afd_d;
			apa_q <= apa_d;
			flp_pulse_q <= flp_d;
		end
	end

	// link mode, carrier and collision
	logic sp_d, fd_d, done_d, pen_d, crs_d, col_d;
	always_comb begin
		done_d = an_en && (an_q == AN_DONE);
		sp_d = an_en ? asp_q : phy_ctrl0[PHY0_SPEED_BIT];
		fd_d = an_en ? afd_q : phy_ctrl0[PHY0_DUPLEX_BIT];
		pen_d = done_d && afd_q && apa_q;
		crs_d = crs_rx_q || (!full_duplex_q && tx_active);
		col_d = !full_duplex_q && tx_active && crs_rx_q;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			speed100_q <= 1'b0;
			full_duplex_q <= 1'b0;
			an_done_q <= 1'b0;
			pause_en_q <= 1'b0;
			crs_q <= 1'b0;
			col_q <= 1'b0;
		end else begin
			speed100_q <= sp_d;
			full_duplex_q <= fd_d;
			an_done_q <= done_d;
			pause_en_q <= pen_d;
			crs_q <= crs_d;
			col_q <= col_d;
		end
	end

	// pause timer; only new frame starts are held, a frame in flight runs on
	logic [11:0] slot_q, slot_d, slot_len;
	logic [15:0] tmr_d;
	logic pse_d, pause_hit;
	always_comb begin
		slot_len = speed100_q ? SLOT_CYC_100 : SLOT_CYC_10;
		pause_hit = ctrl_frame_stb && pause_en_q &&
			(ctrl_opcode == PAUSE_OPCODE);
		slot_d = slot_q;
		tmr_d = pause_timer_q;
		pse_d = tx_pause_q;
		if (pause_hit) begin
			tmr_d = ctrl_param;
			pse_d = (ctrl_param != 16'h0000);
			slot_d = 12'h000;
		end else if (tx_pause_q) begin
			slot_d = slot_q + 12'h001;
			if (slot_q == slot_len - 12'h001) begin
				slot_d = 12'h000;
				tmr_d = pause_timer_q - 16'h0001;
				pse_d = (pause_timer_q != 16'h0001);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			slot_q <= 12'h000;
			pause_timer_q <= 16'h0000;
			tx_pause_q <= 1'b0;
		end else begin
			slot_q <= slot_d;
			pause_timer_q <= tmr_d;
			tx_pause_q <= pse_d;
		end
	end

	fd_no_col_a: assert property (@(posedge clk_sys) disable iff (rst)
		full_duplex_q |=> !col_q)
		else $error("collision shown in full duplex");
	half_crs_tx_a: assert property (@(posedge clk_sys) disable iff (rst)
		(!full_duplex_q && tx_active) |=> crs_q)
		else $error("half duplex carrier missing while sending");
	full_crs_rx_a: assert property (@(posedge clk_sys) disable iff (rst)
		(full_duplex_q && !crs_rx_q) |=> !crs_q)
		else $error("full duplex carrier without reception");
	half_col_a: assert property (@(posedge clk_sys) disable iff (rst)
		(!full_duplex_q && tx_active && crs_rx_q) |=> col_q)
		else $error("overlap in half duplex without collision");
	pause_load_a: assert property (@(posedge clk_sys) disable iff (rst)
		(pause_hit && ctrl_param != 16'h0000) |=>
		(tx_pause_q && pause_timer_q == $past(ctrl_param)))
		else $error("pause timer not loaded");
	pause_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
		(pause_hit && ctrl_param == 16'h0000) |=> !tx_pause_q)
		else $error("zero pause did not end pause");
	pause_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
		(!tx_pause_q && (!pause_en_q || ctrl_opcode != PAUSE_OPCODE))
		|=> !tx_pause_q)
		else $error("pause entered without a valid request");
	slot_dec_a: assert property (@(posedge clk_sys) disable iff (rst)
		(tx_pause_q && !pause_hit && slot_q == slot_len - 12'h001) |=>
		(pause_timer_q == $past(pause_timer_q) - 16'h0001))
		else $error("pause timer missed a slot");
	soft_reset_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(host_ctrl0_q[HOST0_RESET_BIT] && !host_ctrl0_wr) |=>
		(!host_ctrl0_q[HOST0_RESET_BIT] && an_q == AN_IDLE && !tx_pause_q))
		else $error("software reset did not clear");
	loop_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
		(loop_en && tx_bit_stb) |=> (line_tx_nrzi_q != $past(line_tx_nrzi_q)))
		else $error("line not sending idle in loop-back");
endmodule : plpc_top
`default_nettype wire

// file: hdl/plpc_pkg.sv
// constants, types and helper functions for the link and pause control block
package plpc_pkg;
	localparam longint CLK_HZ = 40000000;
	localparam int CLK_MHZ = 40;
	localparam int PHY0_LOOP_BIT = 14;
	localparam int PHY0_SPEED_BIT = 13;
	localparam int PHY0_AN_EN_BIT = 12;
	localparam int PHY0_DUPLEX_BIT = 8;
	localparam int HOST0_RESET_BIT = 0;
	localparam int ADV_10HD_BIT = 5;
	localparam int ADV_10FD_BIT = 6;
	localparam int ADV_100HD_BIT = 7;
	localparam int ADV_100FD_BIT = 8;
	localparam int ADV_PAUSE_BIT = 10;
	localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
	localparam longint SLOT_BITS = 512;
	localparam longint RATE_100 = 100000000;
	localparam longint RATE_10 = 10000000;
	localparam logic [11:0] SLOT_CYC_100 =
		12'((SLOT_BITS * CLK_HZ + RATE_100 - 1) / RATE_100);
	localparam logic [11:0] SLOT_CYC_10 =
		12'((SLOT_BITS * CLK_HZ + RATE_10 - 1) / RATE_10);
	localparam int FLP_BIT_US = 125;
	localparam int ADV_BITS = 16;
	localparam int CS_WIN = 10;
	localparam logic [2:0] GROUP_LAST = 3'h4;
	localparam logic [10:0] DESCR_SEED = 11'h7ff;
	localparam logic [4:0] CG_IDLE = 5'h1f;
	localparam logic [4:0] CG_J = 5'h18;
	localparam logic [4:0] CG_K = 5'h11;
	localparam logic [4:0] CG_T = 5'h0d;
	localparam logic [4:0] CG_R = 5'h07;
	localparam int RX_FIFO_DEPTH = 4;
	localparam int NIB_W = 4;

	typedef enum logic [1:0] {AN_IDLE, AN_SEND, AN_WAIT, AN_DONE} plpc_an_t;

	// true when two zeros at least two positions apart sit in the window
	function automatic logic plpc_two_zeros(input logic [CS_WIN-1:0] w);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < CS_WIN; i++) begin
			for (int j = i + 2; j < CS_WIN; j++) begin
				if (!w[i] && !w[j]) begin
					hit = 1'b1;
				end
			end
		end
		return hit;
	endfunction : plpc_two_zeros

	// returns {valid, nibble}; control and unknown groups are not valid
	function automatic logic [4:0] plpc_decode(input logic [4:0] g);
		logic [4:0] r;
		r = 5'h00;
		case (g)
			5'h1e: r = 5'h10;
			5'h09: r = 5'h11;
			5'h14: r = 5'h12;
			5'h15: r = 5'h13;
			5'h0a: r = 5'h14;
			5'h0b: r = 5'h15;
			5'h0e: r = 5'h16;
			5'h0f: r = 5'h17;
			5'h12: r = 5'h18;
			5'h13: r = 5'h19;
			5'h16: r = 5'h1a;
			5'h17: r = 5'h1b;
			5'h1a: r = 5'h1c;
			5'h1b: r = 5'h1d;
			5'h1c: r = 5'h1e;
			5'h1d: r = 5'h1f;
			default: r = 5'h00;
		endcase
		return r;
	endfunction : plpc_decode
endpackage : plpc_pkg

// file: hdl/plpc_stream_if.sv
// valid and ready stream carrier between the block's own modules
`timescale 1ns/10ps
`default_nettype none
interface plpc_stream_if #(parameter int W = 4);
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : plpc_stream_if
`default_nettype wire

// file: hdl/plpc_fifo.sv
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module plpc_fifo #(
	parameter int W = 4,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// fill and drain sides
	plpc_stream_if.snk wr,
	plpc_stream_if.src rd
);
	// depth must be a power of two so the pointers wrap by themselves
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [W-1:0] mem_d [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0] cnt_q, cnt_d;
	logic do_wr, do_rd;

	assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
	assign rd.valid = (cnt_q != '0);
	assign rd.data = mem_q[rp_q];

	always_comb begin
		do_wr = wr.valid && wr.ready;
		do_rd = rd.valid && rd.ready;
		mem_d = mem_q;
		wp_d = wp_q;
		rp_d = rp_q;
		cnt_d = cnt_q;
		if (do_wr) begin
			mem_d[wp_q] = wr.data;
			wp_d = wp_q + 1'b1;
		end
		if (do_rd) begin
			rp_d = rp_q + 1'b1;
		end
		if (do_wr && !do_rd) begin
			cnt_d = cnt_q + 1'b1;
		end else if (do_rd && !do_wr) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
			mem_q <= mem_d;
		end
	end
endmodule : plpc_fifo
`default_nettype wire

// file: tb/plpc_partner.sv
// remote link partner: serial line bits and its ability word
`timescale 1ns/10ps
`default_nettype none
module plpc_partner (
	// clock
	input wire logic clk_sys,
	// line toward the block
	output logic line_rx_nrzi,
	output logic line_rx_bit_tgl,
	// ability word
	output logic lp_word_stb,
	output logic [15:0] lp_word
);
	initial begin
		line_rx_nrzi = 1'b0;
		line_rx_bit_tgl = 1'b0;
		lp_word_stb = 1'b0;
		lp_word = 16'h0000;
	end

	// bits go 4 cycles apart so the two-flop synchroniser sees each toggle
	task automatic send_bits(input logic [15:0] b, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			@(negedge clk_sys);
			line_rx_nrzi = line_rx_nrzi ^ b[i];
			line_rx_bit_tgl = ~line_rx_bit_tgl;
			repeat (3) @(negedge clk_sys);
		end
	endtask : send_bits

	task automatic offer(input logic [15:0] w);
		@(negedge clk_sys);
		lp_word = w;
		lp_word_stb = 1'b1;
		@(negedge clk_sys);
		lp_word_stb = 1'b0;
		// word no longer valid once the strobe is gone
		lp_word = ~w;
	endtask : offer
endmodule : plpc_partner
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the link and pause control block
`timescale 1ns/10ps
`default_nettype none
module testbench import plpc_pkg::*;;
	localparam int FLP = 20;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic host_ctrl0_wr = 1'b0;
	logic [15:0] host_ctrl0_wdata = 16'h0000;
	logic [15:0] phy_ctrl0 = 16'h0000;
	logic [15:0] phy_adv4 = 16'h0000;
	logic tx_nrz_bit = 1'b0;
	logic tx_bit_stb = 1'b0;
	logic tx_active = 1'b0;
	logic rx_nib_ready = 1'b0;
	logic ctrl_frame_stb = 1'b0;
	logic [15:0] ctrl_opcode = 16'h0000;
	logic [15:0] ctrl_param = 16'h0000;
	logic line_rx_nrzi, line_rx_bit_tgl, lp_word_stb;
	logic [15:0] lp_word, host_ctrl0_q, pause_timer_q;
	logic [3:0] rx_nib_q;
	logic line_tx_nrzi_q, line_tx_man_q, flp_pulse_q, rx_nib_vld_q;
	logic rx_overrun_q, rx10_bit_q, rx10_stb_q, crs_q, col_q;
	logic speed100_q, full_duplex_q, an_done_q, pause_en_q, tx_pause_q;
	logic [31:0] rng = 32'hb5217dea;
	int n_mismatch = 0;
	int check_count = 0;
	int n_flp = 0;
	int c0;
	int m_timer = 0;
	logic m_en = 1'b0;

	plpc_top #(.FLP_BIT_CYC(FLP)) plpc_top_i (
		.clk_sys, .reset_n, .host_ctrl0_wr, .host_ctrl0_wdata, .host_ctrl0_q,
		.phy_ctrl0, .phy_adv4, .line_rx_nrzi, .line_rx_bit_tgl,
		.line_tx_nrzi_q, .line_tx_man_q, .flp_pulse_q, .lp_word_stb,
		.lp_word, .tx_nrz_bit, .tx_bit_stb, .tx_active, .rx_nib_q,
		.rx_nib_vld_q, .rx_nib_ready, .rx_overrun_q, .rx10_bit_q,
		.rx10_stb_q, .crs_q, .col_q, .speed100_q, .full_duplex_q,
		.an_done_q, .pause_en_q, .ctrl_frame_stb, .ctrl_opcode,
		.ctrl_param, .tx_pause_q, .pause_timer_q
	);

	plpc_partner plpc_partner_i (
		.clk_sys, .line_rx_nrzi, .line_rx_bit_tgl, .lp_word_stb, .lp_word
	);

	always #12.5 clk_sys = ~clk_sys;

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : xs

	// consumer readiness and the transmit bit stream stay busy all run
	always @(negedge clk_sys) begin
		rng = xs(rng);
		rx_nib_ready = rng[0];
		tx_nrz_bit = rng[1];
		tx_bit_stb = ~tx_bit_stb;
	end

	always @(posedge clk_sys) begin
		if (flp_pulse_q === 1'b1) begin
			n_flp++;
		end
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask : check

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results

	task automatic hw(input logic [15:0] w);
		@(negedge clk_sys);
		host_ctrl0_wr = 1'b1;
		host_ctrl0_wdata = w;
		@(negedge clk_sys);
		host_ctrl0_wr = 1'b0;
		host_ctrl0_wdata = ~w;
		check(host_ctrl0_q, w);
		@(negedge clk_sys);
		check(host_ctrl0_q, w & 16'hfffe);
		m_timer = 0;
	endtask : hw

	// model: only an enabled pause with the right opcode reloads the timer
	// each strobe stands for a frame that already passed the address filter
	task automatic pause(input logic [15:0] op, input logic [15:0] prm);
		@(negedge clk_sys);
		ctrl_frame_stb = 1'b1;
		ctrl_opcode = op;
		ctrl_param = prm;
		@(negedge clk_sys);
		ctrl_frame_stb = 1'b0;
		ctrl_opcode = ~op;
		ctrl_param = ~prm;
		if (m_en && op === PAUSE_OPCODE) begin
			m_timer = prm;
		end
		check(pause_timer_q, 16'(m_timer));
		check(16'(tx_pause_q), 16'(m_timer != 0));
	endtask : pause

	initial begin
		repeat (10) @(negedge clk_sys);
		reset_n = 1'b1;
		check(host_ctrl0_q | pause_timer_q, 16'h0000);
		hw(rng[15:0] | 16'h0001);
		pause(PAUSE_OPCODE, 16'h0005);
		tx_active = 1'b1;
		repeat (3) @(negedge clk_sys);
		check(16'({speed100_q, full_duplex_q, crs_q}), 16'h1);
		phy_ctrl0 = 16'h2100;
		repeat (3) @(negedge clk_sys);
		check(16'({speed100_q, full_duplex_q, crs_q}), 16'h6);
		plpc_partner_i.send_bits(16'h035f, 10);
		for (int i = 0; i < 20 && crs_q !== 1'b1; i++) @(negedge clk_sys);
		check(16'({crs_q, col_q}), 16'h2);
		// last group 11110 after de-scrambling decodes to nibble 0
		for (int i = 0; i < 40 && rx_nib_vld_q !== 1'b1; i++)
			@(negedge clk_sys);
		check(16'({rx_nib_vld_q, rx_nib_q}), 16'h10);
		check(16'(rx_overrun_q), 16'h0);
		phy_ctrl0 = 16'h2000;
		repeat (3) @(negedge clk_sys);
		check(16'({crs_q, col_q}), 16'h3);
		tx_active = 1'b0;
		// loop-back keeps the line toggling idle, one toggle per strobe
		phy_ctrl0 = 16'h6100;
		repeat (3) @(negedge clk_sys);
		c0 = int'(line_tx_nrzi_q);
		repeat (2) @(negedge clk_sys);
		check(16'(line_tx_nrzi_q ^ c0[0]), 16'h1);
		phy_ctrl0 = 16'h1000;
		phy_adv4 = 16'h05e0;
		// partner offers mode k and all below it, so k is the common best
		for (int k = 0; k < 4; k++) begin
			hw(16'h0001);
			for (int i = 0; i < 50 && flp_pulse_q !== 1'b1; i++)
				@(negedge clk_sys);
			check(16'(flp_pulse_q), 16'h1);
			c0 = n_flp;
			plpc_partner_i.offer(16'h0400 | (((16'h0040 << k) - 1) & 16'hffe0));
			repeat (16 * FLP - 2) @(negedge clk_sys);
			check(16'(n_flp - c0), 16'd21);
			for (int i = 0; i < 1000 && an_done_q !== 1'b1; i++)
				@(negedge clk_sys);
			check(16'({an_done_q, speed100_q, full_duplex_q, pause_en_q}),
				16'({1'b1, k > 1, k[0], k[0]}));
		end
		m_en = 1'b1;
		pause(PAUSE_OPCODE + 16'h0001, rng[15:0]);
		pause(PAUSE_OPCODE, rng[31:16] | 16'h0100);
		repeat (150) @(negedge clk_sys);
		check(pause_timer_q, 16'(m_timer));
		repeat (60) @(negedge clk_sys);
		check(pause_timer_q, 16'(m_timer - 1));
		pause(PAUSE_OPCODE, 16'hffff);
		pause(PAUSE_OPCODE, 16'h0000);
		pause(PAUSE_OPCODE, 16'h0001);
		repeat (210) @(negedge clk_sys);
		check(pause_timer_q | 16'(tx_pause_q), 16'h0000);
		results();
	end

	// whole run needs well under 10000 cycles
	initial begin
		#500000;
		n_mismatch++;
		results();
	end
endmodule : testbench
`default_nettype wire
